//--- rtl/uetx_port.sv
// Egress PHY transmit port: octet stream in, UTOPIA transmit pins out.
// Assumes PHY inputs are synchronous to clk_sys_i and cells enter with
// their first octet flagged by soc; configuration bits are plain inputs.
`timescale 1ns/10ps

// Contract
// - A low level on the PHY full input means the PHY is full.
// - Octets go out on the data bus and are valid only while enable is active.
// - The parity output is odd parity over the data octet whenever enable is active.
// - Start-of-cell is high with the first octet of each cell while enable is active.
// - Enable is low exactly in the cycles where data, parity and start-of-cell are valid.
// - A low cell-clear input discards the cell currently being sent.
// - In Level 1 a four-bit port-ID output names the PHY of the current or next cell.
// - A configuration bit chooses whether the port-ID refers to the current or next cell.
// - In next-cell mode port-ID-valid is low while port-ID is valid; unused otherwise.
// - In Level 2 the address outputs carry the low four bits of the selected PHY.
// - In Level 2 a separate output carries the address MSB, five bits in all.
module uetx_port #(
  parameter int unsigned CELL_OCTETS = uetx_pkg::CELL_LEN,
  parameter int unsigned DEPTH       = uetx_pkg::FIFO_DEPTH
) (
  input  wire logic               clk_sys_i,
  input  wire logic               nrst_i,
  // Configuration bits of the general config register
  input  wire logic               cfg_level2_i,
  input  wire logic               cfg_next_id_i,
  // Octet stream from the cell processor
  input  wire logic               in_valid_i,
  output logic                    in_ready_o,
  input  wire uetx_pkg::uetx_word_t in_word_i,
  // PHY transmit pins
  input  wire logic               tx_full_n_i,
  input  wire logic               tx_cell_abort_n_i,
  output logic [7:0]              tx_data_o,
  output logic                    tx_parity_o,
  output logic                    tx_soc_o,
  output logic                    tx_enb_n_o,
  output logic [3:0]              tx_port_id_o,
  output logic                    tx_port_id_valid_n_o,
  output logic                    tx_addr4_o
);
  localparam int unsigned CW = $clog2(CELL_OCTETS);

  uetx_pkg::uetx_state_t state_q;
  uetx_pkg::uetx_state_t state_d;
  uetx_pkg::uetx_word_t  head;
  logic                  head_vld;
  logic                  fifo_in_rdy;
  logic                  pop;
  logic                  send;
  logic                  start;
  logic [CW-1:0]         oct_q;
  logic                  last_oct;

  // Buffer between producer and PHY; ready stalls the producer
  uetx_fifo #(
    .WIDTH (uetx_pkg::WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (in_valid_i),
    .in_ready_o  (fifo_in_rdy),
    .in_data_i   (in_word_i),
    .out_valid_o (head_vld),
    .out_ready_i (pop),
    .out_data_o  (head)
  );

  assign in_ready_o = fifo_in_rdy;
  assign last_oct   = (oct_q == CW'(CELL_OCTETS - 1));

  // Start only on a cell head with PHY room; full low is full
  assign start = (state_q == uetx_pkg::UETX_IDLE) && head_vld && head.soc
                 && tx_full_n_i && tx_cell_abort_n_i;

  // Mid-cell octets move while the PHY has room and no clear is seen
  assign send = start || ((state_q == uetx_pkg::UETX_SEND) && head_vld
                && tx_full_n_i && tx_cell_abort_n_i);

  // Drop pops stray octets; a new soc ends the drop without popping
  always_comb begin
    pop = send;
    unique case (state_q)
      uetx_pkg::UETX_IDLE: if (head_vld && !head.soc) pop = 1'b1;
      uetx_pkg::UETX_DROP: if (head_vld && !head.soc) pop = 1'b1;
      uetx_pkg::UETX_SEND: ;
    endcase
  end

  // Cell sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      uetx_pkg::UETX_IDLE: begin
        if (start && !last_oct) begin
          state_d = uetx_pkg::UETX_SEND;
        end
      end
      uetx_pkg::UETX_SEND: begin
        if (!tx_cell_abort_n_i) begin
          state_d = uetx_pkg::UETX_DROP;
        end else if (send && last_oct) begin
          state_d = uetx_pkg::UETX_IDLE;
        end
      end
      uetx_pkg::UETX_DROP: begin
        if (head_vld && head.soc) begin
          state_d = uetx_pkg::UETX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_q <= uetx_pkg::UETX_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Octet position inside the cell
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      oct_q <= '0;
    end else if (state_d != uetx_pkg::UETX_SEND) begin
      oct_q <= (start && !last_oct) ? CW'(1) : '0;
    end else if (send) begin
      oct_q <= oct_q + CW'(1);
    end
  end

  // Data path pins; held when idle so only enable moves
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tx_data_o   <= 8'h00;
      tx_parity_o <= 1'b1;
      tx_soc_o    <= 1'b0;
    end else if (send) begin
      tx_data_o   <= head.data;
      tx_parity_o <= ~^head.data;
      tx_soc_o    <= start;
    end
  end

  // Enable low exactly with a freshly loaded octet
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tx_enb_n_o <= uetx_pkg::ENB_N_RST;
    end else begin
      tx_enb_n_o <= !send;
    end
  end

  // PHY addressing; next-cell mode shows the waiting cell head
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      tx_port_id_o         <= 4'h0;
      tx_addr4_o           <= 1'b0;
      tx_port_id_valid_n_o <= uetx_pkg::VLD_N_RST;
    end else if (cfg_level2_i) begin
      tx_port_id_valid_n_o <= 1'b1;
      if (start || (state_q == uetx_pkg::UETX_IDLE && head_vld && head.soc)) begin
        tx_port_id_o <= head.port[3:0];
        tx_addr4_o   <= head.port[4];
      end
    end else if (cfg_next_id_i) begin
      tx_addr4_o <= 1'b0;
      if (head_vld && head.soc) begin
        tx_port_id_o         <= head.port[3:0];
        tx_port_id_valid_n_o <= 1'b0;
      end else begin
        tx_port_id_valid_n_o <= 1'b1;
      end
    end else begin
      tx_addr4_o           <= 1'b0;
      tx_port_id_valid_n_o <= 1'b1;
      if (start) begin
        tx_port_id_o <= head.port[3:0];
      end
    end
  end

  // Checks
  a_full_blocks: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !tx_full_n_i |=> tx_enb_n_o)
    else $error("Octet sent while PHY full");
  a_data_follows: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    send |=> !tx_enb_n_o && tx_data_o == $past(head.data))
    else $error("Sent octet differs from FIFO head");
  a_parity_odd: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !tx_enb_n_o |-> ^{tx_parity_o, tx_data_o})
    else $error("Parity not odd");
  a_soc_first: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !tx_enb_n_o |-> tx_soc_o == $past(state_q == uetx_pkg::UETX_IDLE))
    else $error("Start of cell misplaced");
  a_enb_exact: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !tx_enb_n_o |-> $past(head_vld && pop))
    else $error("Enable without popped octet");
  a_abort_drops: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state_q == uetx_pkg::UETX_SEND && !tx_cell_abort_n_i)
    |=> tx_enb_n_o && state_q == uetx_pkg::UETX_DROP)
    else $error("Cell not discarded on clear");
  a_cur_id: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (start && !cfg_level2_i && !cfg_next_id_i)
    |=> tx_port_id_o == $past(head.port[3:0]) && tx_port_id_valid_n_o)
    else $error("Current-cell port ID wrong");
  a_next_valid: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!cfg_level2_i && cfg_next_id_i && head_vld && head.soc)
    |=> !tx_port_id_valid_n_o && tx_port_id_o == $past(head.port[3:0]))
    else $error("Next-cell port ID not valid");
  a_l2_addr: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (start && cfg_level2_i) |=> {tx_addr4_o, tx_port_id_o} == $past(head.port))
    else $error("Level 2 address wrong");
  a_no_start_full: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state_q == uetx_pkg::UETX_IDLE && !tx_full_n_i) |=> !tx_soc_o || tx_enb_n_o)
    else $error("Cell started while PHY full");

  // Octets seen on the pins since the last start-of-cell; checks only
  logic [CW:0] wire_cnt_q;

  // Restarts on every soc octet, so an aborted cell never carries over
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wire_cnt_q <= '0;
    end else if (!tx_enb_n_o) begin
      wire_cnt_q <= tx_soc_o ? (CW+1)'(1) : wire_cnt_q + (CW+1)'(1);
    end
  end

  // A cell never runs past its octet count
  a_cell_bound: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!tx_enb_n_o && !tx_soc_o) |-> wire_cnt_q < (CW+1)'(CELL_OCTETS))
    else $error("Cell longer than its octet count");

  // Pins quiet while reset is held
  a_reset_idle: assert property (@(posedge clk_sys_i)
    !nrst_i |=> tx_enb_n_o && !tx_soc_o && tx_port_id_valid_n_o)
    else $error("Pins active after reset");

  // Level 2 address MSB follows the selected cell
  a_l2_msb: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (start && cfg_level2_i) |=> tx_addr4_o == $past(head.port[4]))
    else $error("Level 2 address MSB wrong");

  // Level 1 has no fifth address bit
  a_l1_msb_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !cfg_level2_i |=> !tx_addr4_o)
    else $error("Address MSB set in Level 1");

  // Current-cell mode leaves the valid pin idle
  a_cur_unused: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!cfg_level2_i && !cfg_next_id_i) |=> tx_port_id_valid_n_o)
    else $error("Port ID valid driven in current-cell mode");

  // Next-cell mode: no waiting cell head means no valid ID
  a_next_idle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!cfg_level2_i && cfg_next_id_i && !(head_vld && head.soc)) |=> tx_port_id_valid_n_o)
    else $error("Port ID valid without a waiting cell");

  // Level 2 never uses the valid pin
  a_l2_vld_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    cfg_level2_i |=> tx_port_id_valid_n_o)
    else $error("Port ID valid driven in Level 2");

  // Discarded octets never reach the PHY
  a_drop_quiet: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_q == uetx_pkg::UETX_DROP |=> tx_enb_n_o)
    else $error("Octet sent while discarding");

  // Last octet closes the cell so the next one opens with soc
  a_cell_close: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state_q == uetx_pkg::UETX_SEND && send && last_oct) |=> state_q == uetx_pkg::UETX_IDLE)
    else $error("Cell not closed after last octet");

  // Full PHY freezes the data pins too
  a_stall_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !tx_full_n_i |=> $stable(tx_data_o))
    else $error("Data moved while PHY full");

  // Current-cell ID only changes when a cell starts
  a_cur_id_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!cfg_level2_i && !cfg_next_id_i && !start) |=> $stable(tx_port_id_o))
    else $error("Current-cell port ID moved mid-cell");

  c_cell_done: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    send && last_oct);
  c_abort: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_q == uetx_pkg::UETX_SEND && !tx_cell_abort_n_i);
  c_full_stall: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_q == uetx_pkg::UETX_SEND && !tx_full_n_i && head_vld);
  c_fifo_full: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !fifo_in_rdy);
  c_next_id: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !cfg_level2_i && cfg_next_id_i && !tx_port_id_valid_n_o);
endmodule : uetx_port

//--- common/uetx_pkg.sv
// Shared types and constants of the egress PHY transmit port.
// Assumes one 100 MHz system clock and a synchronous active-low reset.
package uetx_pkg;
  localparam int unsigned CELL_LEN   = 53;  // Octets per cell
  localparam int unsigned FIFO_DEPTH = 8;   // Words in the octet FIFO
  localparam int unsigned ADDR_W     = 5;   // Level 2 PHY address width
  localparam logic        ENB_N_RST  = 1'b1; // Enable idle after reset
  localparam logic        VLD_N_RST  = 1'b1;

  // One octet of a cell with its routing tag
  typedef struct packed {
    logic [ADDR_W-1:0] port;  // Target PHY address
    logic              soc;   // First octet of a cell
    logic [7:0]        data;
  } uetx_word_t;

  localparam int unsigned WORD_W = $bits(uetx_word_t);

  typedef enum logic [1:0] {
    UETX_IDLE,
    UETX_SEND,
    UETX_DROP
  } uetx_state_t;
endpackage : uetx_pkg

//--- rtl/uetx_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; head word is shown ahead while out_valid_o is high.
`timescale 1ns/10ps
module uetx_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Honest flags straight from the occupancy count
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage array, no reset needed
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers wrap; depth is a power of two
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : uetx_fifo

//--- sim/uetx_phy_model.sv
// Behavioural PHY transmit port: captures octets sent by the port.
// Assumes stall_i is driven by the bench just after a clock edge.
`timescale 1ns/10ps
module uetx_phy_model (
  input  wire logic       clk_sys_i,
  input  wire logic       stall_i,
  output logic            tx_full_n_o,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_parity_i,
  input  wire logic       tx_soc_i,
  input  wire logic       tx_enb_n_i,
  input  wire logic [3:0] tx_port_id_i,
  input  wire logic       tx_port_id_valid_n_i,
  input  wire logic       tx_addr4_i
);
  logic [14:0] cap_q[$];
  logic        full_n_q = 1'b1;
  logic [3:0]  nid_q    = 4'h0;
  int          viol     = 0;

  // Full is signalled low while stalled
  assign tx_full_n_o = ~stall_i;

  // Capture octets; an octet right after a full sample is a violation
  always @(posedge clk_sys_i) begin
    if (!tx_enb_n_i) begin
      cap_q.push_back({tx_addr4_i, tx_port_id_i, tx_parity_i, tx_soc_i, tx_data_i});
      if (!full_n_q) viol++;
    end
    if (!tx_port_id_valid_n_i) nid_q <= tx_port_id_i;
    full_n_q <= tx_full_n_o;
  end
endmodule : uetx_phy_model

//--- sim/testbench.sv
// Self-checking bench of the egress PHY transmit port.
// Assumes the PHY model captures every octet sent with enable low.
`timescale 1ns/10ps
module testbench;
  logic                 clk_sys_i = 1'b0;
  logic                 nrst_i    = 1'b0;
  logic                 cfg_level2, cfg_next_id, in_valid, abort_n, stall;
  logic                 in_ready, full_n, enb_n, pid_vld_n, addr4, parity, soc;
  logic [7:0]           data;
  logic [3:0]           pid;
  uetx_pkg::uetx_word_t in_word;
  int                   bad_count = 0;
  int                   n_checks  = 0;

  uetx_port u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cfg_level2_i(cfg_level2),
    .cfg_next_id_i(cfg_next_id), .in_valid_i(in_valid), .in_ready_o(in_ready),
    .in_word_i(in_word), .tx_full_n_i(full_n), .tx_cell_abort_n_i(abort_n),
    .tx_data_o(data), .tx_parity_o(parity), .tx_soc_o(soc), .tx_enb_n_o(enb_n),
    .tx_port_id_o(pid), .tx_port_id_valid_n_o(pid_vld_n), .tx_addr4_o(addr4));
  uetx_phy_model u_phy (.clk_sys_i(clk_sys_i), .stall_i(stall), .tx_full_n_o(full_n),
    .tx_data_i(data), .tx_parity_i(parity), .tx_soc_i(soc), .tx_enb_n_i(enb_n),
    .tx_port_id_i(pid), .tx_port_id_valid_n_i(pid_vld_n), .tx_addr4_i(addr4));

  // 100 MHz clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task step();
    @(posedge clk_sys_i);
    #1;
  endtask : step

  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  // Offer n words; hold each until an edge that sees ready high
  task send_cell(input logic [4:0] p, input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      in_word  = '{port: p, soc: (i == 0), data: 8'(p + i)};
      in_valid = 1'b1;
      k = 0;
      while (in_ready !== 1'b1 && k < 3000) begin
        step();
        k++;
      end
      step();
    end
    in_valid = 1'b0;
  endtask : send_cell

  task wait_cap(input int n);
    int k;
    k = 0;
    while (u_phy.cap_q.size() < n && k < 3000) begin
      step();
      k++;
    end
    repeat (4) step();
  endtask : wait_cap

  // One whole cell in the capture queue from index b
  task check_cell(input int b, input logic [4:0] p, input logic [4:0] e);
    logic [14:0] r;
    for (int j = 0; j < 53; j++) begin
      r = u_phy.cap_q[b + j];
      chk(r[7:0] === 8'(p + j) && r[8] === (j == 0) && r[9] === ~^r[7:0], "octet");
      if (j == 0) chk(r[14:10] === e, "port address");
    end
  endtask : check_cell

  task t_basic();
    u_phy.cap_q.delete();
    send_cell(5'h05, 53);
    wait_cap(53);
    chk(u_phy.cap_q.size() == 53, "cell length");
    check_cell(0, 5'h05, 5'h05);
  endtask : t_basic

  // Full PHY: FIFO fills and refuses, no octet goes out, mid-cell pause
  task t_stall();
    u_phy.cap_q.delete();
    stall = 1'b1;
    fork
      send_cell(5'h0a, 53);
    join_none
    repeat (20) step();
    chk(in_ready === 1'b0 && u_phy.cap_q.size() == 0, "sent while full");
    stall = 1'b0;
    repeat (12) step();
    stall = 1'b1;
    repeat (10) step();
    stall = 1'b0;
    wait fork;
    wait_cap(53);
    check_cell(0, 5'h0a, 5'h0a);
    chk(u_phy.viol == 0 && in_ready === 1'b1, "octet after full");
  endtask : t_stall

  // Clear mid-cell drops the rest; the next cell is whole
  task t_abort();
    int n;
    u_phy.cap_q.delete();
    fork
      send_cell(5'h03, 53);
    join_none
    wait_cap(10);
    abort_n = 1'b0;
    step();
    abort_n = 1'b1;
    // Octets of the cleared cell that made it out before the clear
    n = u_phy.cap_q.size();
    wait fork;
    send_cell(5'h04, 53);
    wait_cap(n + 53);
    chk(n > 0 && n < 53, "cell not cleared");
    chk(u_phy.cap_q.size() == n + 53, "extra octets after clear");
    check_cell(n, 5'h04, 5'h04);
  endtask : t_abort

  task t_level2();
    u_phy.cap_q.delete();
    cfg_level2 = 1'b1;
    send_cell(5'h13, 53);
    wait_cap(53);
    check_cell(0, 5'h13, 5'h13);
    cfg_level2 = 1'b0;
  endtask : t_level2

  task t_next_id();
    u_phy.cap_q.delete();
    cfg_next_id = 1'b1;
    send_cell(5'h0c, 53);
    wait_cap(53);
    chk(u_phy.nid_q === 4'hc && u_phy.cap_q.size() == 53, "next id");
    cfg_next_id = 1'b0;
  endtask : t_next_id

  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // Main sequence after a five-cycle reset
  initial begin
    cfg_level2  = 1'b0;
    cfg_next_id = 1'b0;
    in_valid    = 1'b0;
    abort_n     = 1'b1;
    stall       = 1'b0;
    in_word     = '0;
    repeat (5) step();
    nrst_i = 1'b1;
    step();
    t_basic();
    t_stall();
    t_abort();
    t_level2();
    t_next_id();
    complete_run();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule : testbench
